// file: lgpm_pkg.sv
// package for the shared indicator / general purpose pin mux with straps
// assumes a 32-bit axi4-lite register bus and two shared pins
package lgpm_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [3:0] IND_CFG_ADDR   = 4'h0; // indicator_config_register
  localparam logic [3:0] GPIO_CFG_ADDR  = 4'h4; // buffer type per gpio
  localparam logic [3:0] GPIO_DD_ADDR   = 4'h8; // data and direction
  localparam logic [3:0] STRAP_ADDR     = 4'hC; // straps and crossover
  localparam int         ADDR_W         = 4;
  // ==========================================================================
  // field positions
  localparam int IND_EN_LSB    = 0;  // two per-pin indicator enables
  localparam int IND_STYLE_LSB = 8;  // indicator_driver_style_field[1:0]
  localparam int GPIO_OD_LSB   = 0;  // 1 = open-drain output
  localparam int GPIO_DATA_LSB = 0;  // output data / pin level on read
  localparam int GPIO_DIR_LSB  = 8;  // 1 = output
  localparam int STRAP_LSB     = 0;  // latched straps, read only
  localparam int XOVER_LSB     = 8;  // crossover soft settings port 1, 2
  localparam int NPINS         = 2;
  // ==========================================================================
  // encodings and reset values
  localparam logic [1:0] STYLE_PUSH_PULL = 2'h0; // others: open-drain/source
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  localparam logic [1:0] IND_EN_RST      = 2'h0;
  localparam logic [1:0] STYLE_RST       = 2'h0;
  localparam logic [1:0] PINS_RST        = 2'h0;
  localparam logic [1:0] STRAP_RST       = 2'h3; // pins carry pull-ups
endpackage : lgpm_pkg

// file: lgpm_strap_latch.sv
// latched configuration straps with loader override
// assumes strap levels are already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module lgpm_strap_latch
  import lgpm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       captureReq,
  input  wire logic [1:0] strapIn,
  input  wire logic       overrideValid,
  input  wire logic [1:0] overrideData,
  output var  logic [1:0] strapLatched
);
  logic [1:0] strap_d;
  logic [1:0] strap_q;

  // ==========================================================================
  // hold steady between captures and loader values; a capture wins over a loader value in the same cycle
  always_comb begin
    strap_d = strap_q;
    if (captureReq) begin
      strap_d = strapIn;
    end else if (overrideValid) begin
      strap_d = overrideData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_q <= STRAP_RST;
    end else begin
      strap_q <= strap_d;
    end
  end

  assign strapLatched = strap_q;
endmodule : lgpm_strap_latch
`default_nettype wire

// file: lgpm_pin_mux.sv
// shared indicator / general purpose pin mux with axi4-lite registers
// assumes pin inputs and external_reset_n are asynchronous to clk,
// indicator activity and loader signals come from logic on clk
// Operation
// - enable bit picks indicator, else gpio
// - driver style field picks push-pull or open
// - strap sets polarity only for open style
// - strap 0 active high, 1 active low
// - indicator 1 strap defaults port 2 crossover
// - indicator 0 strap defaults port 1 crossover
// - straps captured at reset and external release
// - loader may replace latched strap values
// - gpio is push-pull, open-drain or input
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lgpm_pin_mux
  import lgpm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              external_reset_n,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // link side
  input  wire logic [1:0]        indicatorActive,
  input  wire logic              eepromStrapValid,
  input  wire logic [1:0]        eepromStrapData,
  output var  logic [1:0]        crossoverEnable,
  // shared pins indicator_pin_0/1 = general_purpose_io_0/1
  input  wire logic [1:0]        pinIn,
  output var  logic [1:0]        pinOut,
  output var  logic [1:0]        pinOe
);
  // ==========================================================================
  // synchronisers for pins and the external reset
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;
  logic       extMeta_q;
  logic       extSync_q;
  logic       extPrev_q;
  logic [2:0] rstHold_q;

  // second stage is the only reader of the first
  always_ff @(posedge clk) begin
    pinMeta_q <= pinIn;
    pinSync_q <= pinMeta_q;
    extMeta_q <= external_reset_n;
    extSync_q <= extMeta_q;
  end

  // release detection; after reset_n the capture repeats for three edges,
  // so the last one sees a pin level sampled after the drivers let go
  // even when reset_n was held for a single edge
  logic captureReq;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rstHold_q <= '1;
      extPrev_q <= 1'b0;
    end else begin
      rstHold_q <= {rstHold_q[1:0], 1'b0};
      extPrev_q <= extSync_q;
    end
  end
  assign captureReq = (|rstHold_q) | (extSync_q & ~extPrev_q);

  logic [1:0] strapLatched;
  lgpm_strap_latch u_strap (
    .clk           (clk),
    .reset_n       (reset_n),
    .captureReq    (captureReq),
    .strapIn       (pinSync_q),
    .overrideValid (eepromStrapValid),
    .overrideData  (eepromStrapData),
    .strapLatched  (strapLatched)
  );

  // ==========================================================================
  // register file and bus slave
  logic [1:0]        indEn_q, indEn_d;
  logic [1:0]        style_q, style_d;
  logic [1:0]        gpioOd_q, gpioOd_d;
  logic [1:0]        gpioData_q, gpioData_d;
  logic [1:0]        gpioDir_q, gpioDir_d;
  logic [1:0]        xover_q, xover_d;
  logic              awHeld_q, awHeld_d;
  logic              wHeld_q, wHeld_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0]       wData_q, wData_d;
  logic [3:0]        wStrb_q, wStrb_d;
  logic              bValid_q, bValid_d;
  logic [1:0]        bResp_q, bResp_d;
  logic              rValid_q, rValid_d;
  logic [1:0]        rResp_q, rResp_d;
  logic [31:0]       rData_q, rData_d;
  logic              awReady_q, awReady_d;
  logic              wReady_q, wReady_d;
  logic              arReady_q, arReady_d;

  // decode used by both read and write paths
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == IND_CFG_ADDR) || (a == GPIO_CFG_ADDR) ||
               (a == GPIO_DD_ADDR) || (a == STRAP_ADDR);
  endfunction : isMapped

  // merge a two-bit field under the byte enable of its lane
  function automatic logic [1:0] laneMerge(input logic [1:0] old,
      input logic [31:0] d, input logic [3:0] s, input int lsb);
    logic [1:0] r;
    r = old;
    if (s[lsb/8]) begin
      r = d[lsb +: 2];
    end
    laneMerge = r;
  endfunction : laneMerge

  // address and data are held separately; the write fires when both are in
  always_comb begin
    indEn_d    = indEn_q;
    style_d    = style_q;
    gpioOd_d   = gpioOd_q;
    gpioData_d = gpioData_q;
    gpioDir_d  = gpioDir_q;
    xover_d    = xover_q;
    awHeld_d   = awHeld_q;
    wHeld_d    = wHeld_q;
    awAddr_d   = awAddr_q;
    wData_d    = wData_q;
    wStrb_d    = wStrb_q;
    bValid_d   = bValid_q;
    bResp_d    = bResp_q;
    rValid_d   = rValid_q;
    rResp_d    = rResp_q;
    rData_d    = rData_q;
    if (s_axi_awvalid && awReady_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (awHeld_q && wHeld_q && !bValid_q) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      unique case (awAddr_q)
        IND_CFG_ADDR: begin
          indEn_d = laneMerge(indEn_q, wData_q, wStrb_q, IND_EN_LSB);
          style_d = laneMerge(style_q, wData_q, wStrb_q, IND_STYLE_LSB);
        end
        GPIO_CFG_ADDR: begin
          gpioOd_d = laneMerge(gpioOd_q, wData_q, wStrb_q, GPIO_OD_LSB);
        end
        GPIO_DD_ADDR: begin
          gpioData_d = laneMerge(gpioData_q, wData_q, wStrb_q,
                                 GPIO_DATA_LSB);
          gpioDir_d  = laneMerge(gpioDir_q, wData_q, wStrb_q, GPIO_DIR_LSB);
        end
        STRAP_ADDR: begin
          xover_d = laneMerge(xover_q, wData_q, wStrb_q, XOVER_LSB);
        end
        default: begin
        end
      endcase
    end
    // a fresh strap value reloads the crossover defaults
    if (captureReq || eepromStrapValid) begin
      xover_d = captureReq ? pinSync_q : eepromStrapData;
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
    if (s_axi_arvalid && arReady_q) begin
      rValid_d = 1'b1;
      rResp_d  = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rData_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        IND_CFG_ADDR: begin
          rData_d[IND_EN_LSB +: 2]    = indEn_q;
          rData_d[IND_STYLE_LSB +: 2] = style_q;
        end
        GPIO_CFG_ADDR: rData_d[GPIO_OD_LSB +: 2] = gpioOd_q;
        GPIO_DD_ADDR: begin
          rData_d[GPIO_DATA_LSB +: 2] = pinSync_q; // live pin level
          rData_d[GPIO_DIR_LSB +: 2]  = gpioDir_q;
        end
        STRAP_ADDR: begin
          rData_d[STRAP_LSB +: 2] = strapLatched;
          rData_d[XOVER_LSB +: 2] = xover_q;
        end
        default: begin
        end
      endcase
    end
    // one write and one read in flight; readies lead the next cycle
    awReady_d = !awHeld_d && !bValid_d;
    wReady_d  = !wHeld_d && !bValid_d;
    arReady_d = !rValid_d;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      indEn_q    <= IND_EN_RST;
      style_q    <= STYLE_RST;
      gpioOd_q   <= PINS_RST;
      gpioData_q <= PINS_RST;
      gpioDir_q  <= PINS_RST;
      xover_q    <= STRAP_RST;
      awHeld_q   <= 1'b0;
      wHeld_q    <= 1'b0;
      awAddr_q   <= '0;
      wData_q    <= 32'h0000_0000;
      wStrb_q    <= 4'h0;
      bValid_q   <= 1'b0;
      bResp_q    <= RESP_OKAY;
      rValid_q   <= 1'b0;
      rResp_q    <= RESP_OKAY;
      rData_q    <= 32'h0000_0000;
      awReady_q  <= 1'b0;
      wReady_q   <= 1'b0;
      arReady_q  <= 1'b0;
    end else begin
      indEn_q    <= indEn_d;
      style_q    <= style_d;
      gpioOd_q   <= gpioOd_d;
      gpioData_q <= gpioData_d;
      gpioDir_q  <= gpioDir_d;
      xover_q    <= xover_d;
      awHeld_q   <= awHeld_d;
      wHeld_q    <= wHeld_d;
      awAddr_q   <= awAddr_d;
      wData_q    <= wData_d;
      wStrb_q    <= wStrb_d;
      bValid_q   <= bValid_d;
      bResp_q    <= bResp_d;
      rValid_q   <= rValid_d;
      rResp_q    <= rResp_d;
      rData_q    <= rData_d;
      awReady_q  <= awReady_d;
      wReady_q   <= wReady_d;
      arReady_q  <= arReady_d;
    end
  end

  // ==========================================================================
  // pin drivers; pins float while the external reset is low so straps read
  logic [1:0] pinOut_q, pinOut_d;
  logic [1:0] pinOe_q, pinOe_d;

  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (indEn_q[i]) begin
        if (style_q == STYLE_PUSH_PULL) begin
          // push-pull ignores the strap and is always active high
          pinOe_d[i]  = 1'b1;
          pinOut_d[i] = indicatorActive[i];
        end else begin
          // open-source when active high, open-drain when active low
          pinOe_d[i]  = indicatorActive[i];
          pinOut_d[i] = ~strapLatched[i];
        end
      end else if (gpioDir_q[i]) begin
        pinOe_d[i]  = gpioOd_q[i] ? ~gpioData_q[i] : 1'b1;
        pinOut_d[i] = gpioOd_q[i] ? 1'b0 : gpioData_q[i];
      end else begin
        pinOe_d[i]  = 1'b0;
        pinOut_d[i] = 1'b0;
      end
      if (!extSync_q) begin
        pinOe_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinOut_q <= PINS_RST;
      pinOe_q  <= PINS_RST;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q  <= pinOe_d;
    end
  end

  // ==========================================================================
  // outputs straight from flops
  assign s_axi_awready   = awReady_q;
  assign s_axi_wready    = wReady_q;
  assign s_axi_bvalid    = bValid_q;
  assign s_axi_bresp     = bResp_q;
  assign s_axi_arready   = arReady_q;
  assign s_axi_rvalid    = rValid_q;
  assign s_axi_rresp     = rResp_q;
  assign s_axi_rdata     = rData_q;
  assign crossoverEnable = xover_q;
  assign pinOut          = pinOut_q;
  assign pinOe           = pinOe_q;
endmodule : lgpm_pin_mux
`default_nettype wire

// file: lgpm_pad_model.sv
// pad model: strap resistors and indicators on the two shared pins
// assumes pinOe high while the block drives a pin
`timescale 1ns/1ps
`default_nettype none
module lgpm_pad_model (
  input  wire logic [1:0] pinOut,
  input  wire logic [1:0] pinOe,
  input  wire logic [1:0] pullLevel,
  output var  logic [1:0] pinLevel
);
  // ==========
  // a released pin settles to its strap resistor, never to the last value
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : pullLevel[i];
    end
  end
endmodule : lgpm_pad_model
`default_nettype wire

// file: lgpm_pin_mux_props.sv
// checker for the pin mux: bus answers, crossover hold, pin release
// assumes one clock and the synchronous active-low reset_n
`timescale 1ns/1ps
`default_nettype none
module lgpm_pin_mux_props
  import lgpm_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              external_reset_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              eepromStrapValid,
  input wire logic [1:0]        eepromStrapData,
  input wire logic [1:0]        crossoverEnable,
  input wire logic [1:0]        pinOe
);
  // ==========
  // cycles since a capture could start; the synchroniser makes it late
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  always_comb begin
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    if (!external_reset_n) quiet_d = 3'h0;
  end
  always_ff @(posedge clk) begin
    quiet_q <= reset_n ? quiet_d : 3'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wtake |=> !s_axi_awready ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_rd_resp;
    s_rtake |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_rd_err;
    s_rtake ##0 (s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_ovr;
    eepromStrapValid && quiet_q == 3'h7
      |=> crossoverEnable == $past(eepromStrapData);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override lost");
  property p_xo_hold;
    quiet_q == 3'h7 && !eepromStrapValid
      |=> $stable(crossoverEnable) || $rose(s_axi_bvalid);
  endproperty
  a_xo_hold: assert property (p_xo_hold) else $error("xover moved");
  property p_ext_float;
    !external_reset_n [*5] |-> pinOe == 2'h0;
  endproperty
  a_ext_float: assert property (p_ext_float)
    else $error("pin driven");
endmodule : lgpm_pin_mux_props
bind lgpm_pin_mux lgpm_pin_mux_props lgpm_pin_mux_props_i (.clk, .reset_n,
  .external_reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .eepromStrapValid, .eepromStrapData, .crossoverEnable,
  .pinOe);
`default_nettype wire

// file: tb.sv
// self-checking bench for the pin mux against a register-level model
// assumes the pad model holds the strap resistors on both pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lgpm_pkg::*;
  // ==========
  logic        clk = 1'h0, reset_n = 1'h0, external_reset_n = 1'h1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        eepromStrapValid = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, crossoverEnable, pinOut, pinOe;
  logic [1:0]  indicatorActive = 2'h0, eepromStrapData = 2'h0, pull = 2'h3;
  logic [1:0]  pinIn, mEn, mSty, mOd, mDat, mDir, mStrap, mXo, eOe, eLvl;
  logic [1:0]  eOut;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  lgpm_pin_mux lgpm_pin_mux_i (.clk, .reset_n, .external_reset_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .indicatorActive, .eepromStrapValid,
    .eepromStrapData, .crossoverEnable, .pinIn, .pinOut, .pinOe);
  lgpm_pad_model lgpm_pad_model_i (.pinOut, .pinOe, .pullLevel(pull),
    .pinLevel(pinIn));
  // clock and a hang guard well above the few hundred cycles needed
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input string w, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %0h got %0h", w, e, g);
    end
  endtask : chk
  // rready is held off one cycle so the slave must keep its read answer; bready rises with bvalid
  task automatic wreg(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    @(posedge clk);
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'h0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge clk);
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_rvalid);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'h0;
  endtask : rreg
  // expected drive and wire level of each pin
  task automatic pins();
    for (int i = 0; i < 2; i++) begin
      if (mEn[i] && mSty == STYLE_PUSH_PULL)
        {eOe[i], eOut[i]} = {1'h1, indicatorActive[i]};
      else if (mEn[i]) {eOe[i], eOut[i]} = {indicatorActive[i], ~mStrap[i]};
      else if (mDir[i] && mOd[i]) {eOe[i], eOut[i]} = {~mDat[i], 1'h0};
      else {eOe[i], eOut[i]} = {mDir[i], mDir[i] & mDat[i]};
    end
    eLvl = (eOe & eOut) | (~eOe & pull);
  endtask : pins
  function automatic logic [31:0] regv(input logic [3:0] a);
    case (a)
      IND_CFG_ADDR:  return {22'h0, mSty, 6'h0, mEn};
      GPIO_CFG_ADDR: return {30'h0, mOd};
      GPIO_DD_ADDR:  return {22'h0, mDir, 6'h0, eLvl};
      default:       return {22'h0, mXo, 6'h0, mStrap};
    endcase
  endfunction : regv
  task automatic sweep();
    pins();
    for (int a = 0; a < 16; a += 4) rreg(4'(a), regv(4'(a)), RESP_OKAY);
    chk("xover", mXo, crossoverEnable);
  endtask : sweep
  task automatic cpins();
    repeat (3) @(posedge clk);
    pins();
    chk("pinOe", eOe, pinOe);
    chk("pinOut", eOut, pinOut);
    chk("pinIn", eLvl, pinIn);
    rreg(GPIO_DD_ADDR, regv(GPIO_DD_ADDR), RESP_OKAY);
  endtask : cpins
  // every driver style code, both pins as indicators
  task automatic leds();
    mEn = 2'h3;
    for (int s = 0; s < 4; s++) begin
      mSty = 2'(s);
      wreg(IND_CFG_ADDR, regv(IND_CFG_ADDR), RESP_OKAY);
      repeat (2) begin
        indicatorActive <= 2'($urandom);
        cpins();
      end
    end
  endtask : leds
  initial begin
    void'($urandom(32'hC139));
    pull = 2'($urandom);
    {mEn, mSty, mOd, mDat, mDir} = 10'h0;
    {mStrap, mXo} = {pull, pull};
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    sweep();
    repeat (8) begin
      {mDir, mOd, mDat} = 6'($urandom);
      wreg(GPIO_CFG_ADDR, regv(GPIO_CFG_ADDR), RESP_OKAY);
      wreg(GPIO_DD_ADDR, {22'h0, mDir, 6'h0, mDat}, RESP_OKAY);
      cpins();
    end
    leds();
    @(posedge clk);
    eepromStrapData <= ~mStrap;
    eepromStrapValid <= 1'h1;
    @(posedge clk);
    eepromStrapValid <= 1'h0;
    {mStrap, mXo} = {~mStrap, ~mStrap};
    sweep();
    leds();
    mXo = 2'($urandom);
    wreg(STRAP_ADDR, {22'h0, mXo, 6'h0, ~mStrap}, RESP_OKAY);
    repeat (20) @(posedge clk);
    sweep();
    external_reset_n <= 1'h0;
    pull <= ~mStrap;
    repeat (6) @(posedge clk);
    chk("pinOe", 2'h0, pinOe);
    external_reset_n <= 1'h1;
    repeat (6) @(posedge clk);
    {mStrap, mXo} = {pull, pull};
    sweep();
    leds();
    wreg(4'h6, 32'hFFFF_FFFF, RESP_SLVERR);
    rreg(4'h2, 32'h0, RESP_SLVERR);
    sweep();
    complete_run();
  end
endmodule : tb
`default_nettype wire
